// *** hw/dcst_scheduler.sv ***
// DMA credit scheduler table with APB register slave
// Behaviour
// [RULE1] Table of 64 software-written 32-bit words, index 0 to 63.
// [RULE2] Each word holds four independent entries, 256 entries total.
// [RULE3] Entry k in byte k: direction at bit 8k+7, channel in low nibble.
// [RULE4] Direction 0 means transmit, 1 means receive.
// [RULE5] Four-bit channel field picks the channel given the credit.
// [RULE6] Transmit entry credits exactly the stored transmit channel.
// [RULE7] Receive entry credits the receive FIFO tied to the channel.
// [RULE8] Shared receive FIFO credit carries the FIFO head channel number.
// [RULE9] Direction and channel write-only reset zero; reserved bits read zero.
// [RULE10] While enable bit 31 is clear, no fetch and no credits.
// [RULE11] Last-entry code n in bits 7-0 gives n+1 valid entries.
// [RULE12] Software fills the table before setting enable.
// [RULE13] Entries visited ascending from 0 to last, then wrap to 0.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dcst_scheduler
  import dcst_pkg::*;
#(
  parameter int WORDS  = DCST_WORDS,
  parameter int CHAN_W = DCST_CHAN_W
) (
  input  wire logic              ref_clk,        // Clock 50 MHz
  input  wire logic              rst,            // Async reset, active high
  input  wire logic              psel,           // APB select
  input  wire logic              penable,        // APB access phase
  input  wire logic              pwrite,         // APB write
  input  wire logic [11:0]       paddr,          // APB byte address
  input  wire logic [31:0]       pwdata,         // APB write data
  output logic      [31:0]       prdata,         // APB read data
  output logic                   pready,         // APB ready
  output logic                   pslverr,        // APB error
  output logic                   creditValid,    // Credit offered
  input  wire logic              creditReady,    // Credit accepted
  output logic                   creditDir,      // 0 transmit, 1 receive
  output logic      [CHAN_W-1:0] creditChannel,  // Credited channel
  output logic      [CHAN_W-1:0] rxFifoQuery,    // Channel whose FIFO is asked
  input  wire logic [CHAN_W-1:0] rxFifoHeadChan  // Head channel of that FIFO
);
  // Table storage and scheduler state
  logic [31:0]       tableMem [WORDS];
  logic [31:0]       ctrlReg;
  logic [7:0]        posReg;
  logic [7:0]        posNext;
  logic              dirReg;
  logic              dirNext;
  logic [CHAN_W-1:0] slotChanReg;
  logic [CHAN_W-1:0] slotChanNext;
  logic [CHAN_W-1:0] chanSel;
  logic [31:0]       prdataReg;
  logic [31:0]       prdataNext;
  logic              errReg;
  logic              errNext;
  dcst_state_type    stateReg;
  dcst_state_type    stateNext;

  // Bus decode
  wire               apbSetup;
  wire               apbAccess;
  wire               hitCtrl;
  wire               hitTable;
  wire               unmapped;
  wire               wrCtrl;
  wire               wrTable;
  wire [11:0]        tableOff;
  wire [5:0]         tableIdx;
  wire [31:0]        ctrlRead;
  wire [31:0]        readMux;

  // Scheduler decode
  wire               enabled;
  wire [7:0]         lastEntry;
  wire [31:0]        curWord;
  wire [7:0]         entryByte;
  wire               atLast;
  wire               fetchNow;
  wire               clearPos;
  wire               handedOff;

  // Byte k of a table word holds entry k
  function automatic logic [7:0] slot_byte(input logic [31:0] w, input logic [1:0] k);
    slot_byte = w[8*k +: 8];
  endfunction

  // Keeps only direction bit and channel nibble; reserved bits stay zero
  function automatic logic [31:0] keep_fields(input logic [31:0] w);
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < DCST_SLOTS; k++) begin
      m[8*k + DCST_DIR_POS]            = w[8*k + DCST_DIR_POS];
      m[8*k + DCST_CHAN_LSB +: CHAN_W] = w[8*k + DCST_CHAN_LSB +: CHAN_W];
    end
    keep_fields = m;
  endfunction

  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign hitCtrl   = (paddr == DCST_CTRL_OFFSET);
  assign hitTable  = (paddr >= DCST_TABLE_OFFSET) &&
                     (paddr < DCST_TABLE_OFFSET + 12'(4 * WORDS)) &&
                     (paddr[1:0] == 2'b00);
  assign unmapped  = ~(hitCtrl | hitTable);
  assign wrCtrl    = apbAccess & pwrite & hitCtrl;
  assign wrTable   = apbAccess & pwrite & hitTable;
  assign tableOff  = paddr - DCST_TABLE_OFFSET;
  assign tableIdx  = tableOff[7:2];
  // Only enable and last entry read back; table words are write-only
  assign ctrlRead  = {ctrlReg[DCST_ENABLE_BIT], 23'h000000, lastEntry};
  assign readMux   = hitCtrl ? ctrlRead : 32'h00000000;  // [RULE9]

  assign enabled   = ctrlReg[DCST_ENABLE_BIT];  // [RULE10]
  assign lastEntry = ctrlReg[DCST_LAST_LSB +: DCST_LAST_W];  // [RULE11]
  assign curWord   = tableMem[posReg[7:2]];  // [RULE1]
  assign entryByte = slot_byte(curWord, posReg[1:0]);  // [RULE2] [RULE3]
  assign atLast    = (posReg >= lastEntry);
  assign fetchNow  = (stateReg == DCST_FETCH) & enabled;
  assign clearPos  = (stateReg == DCST_IDLE) & ~enabled;
  assign handedOff = creditValid & creditReady;

  // Wrap after the last valid entry
  assign posNext      = atLast ? 8'h00 : 8'(posReg + 8'h01);  // [RULE11] [RULE13]
  assign dirNext      = entryByte[DCST_DIR_POS];  // [RULE4]
  assign slotChanNext = entryByte[DCST_CHAN_LSB +: CHAN_W];  // [RULE5]
  assign prdataNext   = (apbSetup & ~pwrite) ? readMux : prdataReg;
  assign errNext      = apbSetup & unmapped;

  assign pready        = 1'b1;
  assign prdata        = prdataReg;
  assign pslverr       = errReg;
  assign creditValid   = (stateReg == DCST_OFFER) & enabled;  // [RULE10]
  assign creditDir     = dirReg;
  assign creditChannel = chanSel;
  assign rxFifoQuery   = slotChanReg;  // [RULE7]

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      DCST_IDLE:  stateNext = enabled ? DCST_FETCH : DCST_IDLE;
      DCST_FETCH: stateNext = enabled ? DCST_OFFER : DCST_IDLE;  // [RULE10]
      DCST_OFFER: begin
        if (!enabled) begin
          stateNext = DCST_IDLE;
        end else if (handedOff) begin
          stateNext = DCST_FETCH;
        end
      end
      default:    stateNext = DCST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= DCST_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlReg <= pwdata;  // [RULE10] [RULE11]
    end
  end

  // One word per register; written values are never read back
  for (genvar w = 0; w < WORDS; w++) begin : gTable
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        tableMem[w] <= DCST_WORD_RESET;  // [RULE9]
      end else if (wrTable && (tableIdx == 6'(w))) begin
        tableMem[w] <= keep_fields(pwdata);  // [RULE1] [RULE3] [RULE9]
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdataReg <= 32'h00000000;
    end else begin
      prdataReg <= prdataNext;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      errReg <= 1'b0;
    end else begin
      errReg <= errNext;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateReg <= DCST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      posReg <= 8'h00;
    end else if (clearPos) begin
      posReg <= 8'h00;  // [RULE13]
    end else if (fetchNow) begin
      posReg <= posNext;  // [RULE13]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dirReg      <= DCST_DIR_TX;
      slotChanReg <= '0;
    end else if (fetchNow) begin
      dirReg      <= dirNext;  // [RULE4]
      slotChanReg <= slotChanNext;  // [RULE5]
    end
  end

  // Transmit: stored channel; receive: head of the associated FIFO
  always_comb begin
    if (dirReg == DCST_DIR_RX) begin
      chanSel = rxFifoHeadChan;  // [RULE7] [RULE8]
    end else begin
      chanSel = slotChanReg;  // [RULE6]
    end
  end
endmodule // dcst_scheduler
`default_nettype wire

// *** hw/dcst_pkg.sv ***
// Constants and types for the DMA credit scheduler table
package dcst_pkg;
  localparam int          DCST_WORDS        = 64;
  localparam int          DCST_SLOTS        = 4;
  localparam int          DCST_CHAN_W       = 4;
  localparam logic [11:0] DCST_CTRL_OFFSET  = 12'h000;
  localparam logic [11:0] DCST_TABLE_OFFSET = 12'h100;
  localparam int          DCST_ENABLE_BIT   = 31;
  localparam int          DCST_LAST_LSB     = 0;
  localparam int          DCST_LAST_W       = 8;
  localparam int          DCST_DIR_POS      = 7;
  localparam int          DCST_CHAN_LSB     = 0;
  localparam logic [31:0] DCST_WORD_RESET   = 32'h00000000;
  localparam logic [31:0] DCST_CTRL_RESET   = 32'h00000000;
  localparam logic        DCST_DIR_TX       = 1'b0;
  localparam logic        DCST_DIR_RX       = 1'b1;
  typedef enum logic [1:0] {DCST_IDLE, DCST_FETCH, DCST_OFFER} dcst_state_type;
endpackage

// *** tb/dcst_properties.sv ***
// Checker for the credit scheduler ports
`timescale 1ns/100ps
`default_nettype none
module dcst_properties (
  input wire logic        ref_clk,        // Clock
  input wire logic        rst,            // Reset
  input wire logic        psel,           // APB select
  input wire logic        penable,        // APB access phase
  input wire logic        pwrite,         // APB write
  input wire logic [11:0] paddr,          // APB address
  input wire logic [31:0] pwdata,         // APB write data
  input wire logic [31:0] prdata,         // APB read data
  input wire logic        pslverr,        // APB error
  input wire logic        creditValid,    // Credit offered
  input wire logic        creditReady,    // Credit accepted
  input wire logic        creditDir,      // Credit direction
  input wire logic [3:0]  creditChannel,  // Credited channel
  input wire logic [3:0]  rxFifoQuery,    // FIFO asked
  input wire logic [3:0]  rxFifoHeadChan  // FIFO head channel
);
  logic enReg;
  wire  acc = psel && penable;
  wire  ctlWr = acc && pwrite && paddr == 12'h000;
  wire  bad = paddr[1:0] != 2'h0 || (paddr != 12'h000 && paddr[11:8] != 4'h1);
  always_ff @(posedge ref_clk or posedge rst) if (rst) enReg <= 1'b0;
    else if (ctlWr) enReg <= pwdata[31];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_idle_quiet: assert property (!enReg |-> !creditValid) else $error("credit off");
  a_start_delay: assert property ($rose(enReg) |-> !creditValid ##1 !creditValid ##1 creditValid)
    else $error("start delay");
  a_offer_holds: assert property (creditValid && !creditReady && !ctlWr |=> creditValid
    && $stable(creditDir) && $stable(rxFifoQuery)) else $error("offer moved");
  a_fetch_gap: assert property (creditValid && creditReady |=> !creditValid)
    else $error("no gap");
  a_rx_head: assert property (creditValid && creditDir |-> creditChannel == rxFifoHeadChan)
    else $error("rx head");
  a_bad_addr: assert property (acc |-> pslverr == bad) else $error("pslverr");
  a_table_wo: assert property (acc && !pwrite && !bad && paddr[8] |-> prdata == 32'h0)
    else $error("table read");
  a_ctrl_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31] == enReg)
    else $error("enable read");
endmodule // dcst_properties
bind dcst_scheduler dcst_properties u_props (.*);
`default_nettype wire

// *** tb/dcst_engine_model.sv ***
// Transfer engine model that takes credits
`timescale 1ns/100ps
`default_nettype none
module dcst_engine_model (
  input  wire logic       ref_clk,        // Clock
  input  wire logic       slow,           // Stall mode
  input  wire logic       creditValid,    // Credit offered
  input  wire logic       creditDir,      // Credit direction
  input  wire logic [3:0] creditChannel,  // Credited channel
  input  wire logic [3:0] rxFifoQuery,    // FIFO asked
  output logic            creditReady,    // Credit taken
  output logic      [3:0] rxFifoHeadChan  // Shared FIFO head
);
  logic [4:0] got[$];
  logic       readyReg = 1'b0;
  assign creditReady    = readyReg;
  assign rxFifoHeadChan = 4'(rxFifoQuery + 4'h1);
  always @(posedge ref_clk) begin
    if (creditValid && creditReady) got.push_back({creditDir, creditChannel});
    readyReg <= slow ? !readyReg : 1'b1;
  end
endmodule // dcst_engine_model
`default_nettype wire

// *** tb/testbench.sv ***
// Testbench for the credit scheduler
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dcst_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        er, pready, pslverr, creditValid, creditReady, creditDir;
  logic [3:0]  creditChannel, rxFifoQuery, rxFifoHeadChan;
  logic [7:0]  ent [8] = '{8'h73, 8'h81, 8'h0F, 8'h8A, 8'h05, 8'h8E, 8'h00, 8'h00};
  int          failCount = 0, checkCount = 0;
  always #10 ref_clk = !ref_clk;
  dcst_scheduler u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .creditValid(creditValid), .creditReady(creditReady), .creditDir(creditDir),
    .creditChannel(creditChannel), .rxFifoQuery(rxFifoQuery), .rxFifoHeadChan(rxFifoHeadChan)
  );
  dcst_engine_model u_eng (
    .ref_clk(ref_clk), .slow(slow), .creditValid(creditValid), .creditDir(creditDir),
    .creditChannel(creditChannel), .rxFifoQuery(rxFifoQuery), .creditReady(creditReady),
    .rxFifoHeadChan(rxFifoHeadChan)
  );
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    checkCount++;
    if (s !== e) begin
      failCount++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_regs;
    apb(1'b1, DCST_TABLE_OFFSET, 32'hFFFFFFFF);
    apb(1'b0, DCST_TABLE_OFFSET, 32'h0);
    chk("table word", 32'h0, rd);
    apb(1'b0, 12'h1FC, 32'h0);
    chk("word 63", 32'h0, rd | {31'h0, er});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, DCST_CTRL_OFFSET, 32'h000000FF);
    apb(1'b0, DCST_CTRL_OFFSET, 32'h0);
    chk("control", 32'h000000FF, rd);
    $display("t_regs done");
  endtask
  task automatic t_run(input logic [7:0] last, input int n);
    logic [7:0] b;
    apb(1'b1, DCST_TABLE_OFFSET, {ent[3], ent[2], ent[1], ent[0]});
    apb(1'b1, DCST_TABLE_OFFSET + 12'h004, {ent[7], ent[6], ent[5], ent[4]});
    u_eng.got.delete();
    apb(1'b1, DCST_CTRL_OFFSET, {1'b1, 23'h0, last});
    for (int i = 0; i < 400 && u_eng.got.size() < n; i++) @(posedge ref_clk);
    apb(1'b1, DCST_CTRL_OFFSET, 32'h0);
    for (int i = 0; i < n; i++) begin
      b = ent[i % (last + 1)];
      chk("credit", {b[7], b[7] ? b[3:0] + 4'h1 : b[3:0]}, u_eng.got[i]);
    end
    $display("t_run done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_run(8'h05, 8);
    slow <= 1'b0;
    t_run(8'h00, 3);
    summarize();
  end
  initial begin
    #200000;
    failCount++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
